// file: src/sensor_cfg_map.vh
// Register offsets, field positions, reset values and timing counts of the sensor setup logic.
`ifndef SENSOR_CFG_MAP_VH
`define SENSOR_CFG_MAP_VH
`define SETUP_OFFSET 8'h00
`define FLAGS_OFFSET 8'h01
`define SETUP_RESET 16'h0000
`define FLAGS_RESET 12'h000
`define SETUP_WRITE_MASK 16'hffbf
`define ALERT_MODE_LSB 1
`define THERM_CUR_LSB 4
`define SHUTDOWN_BIT 7
`define EXT_RES_BIT 8
`define EXT_REF_BIT 9
`define AVG_LSB 10
`define P_BYPASS_BIT 13
`define T_BYPASS_BIT 14
`define NVM_DISABLE_BIT 15
`define DRIVE_FAULT_BIT 11
`define SENSE_FAULT_BIT 10
`define T_READY_BIT 9
`define P_READY_BIT 8
`define MODE_IRQ 3'h0
`define MODE_PWM 3'h1
`define MODE_CASE1 3'h2
`define MODE_CASE2 3'h3
`define MODE_CASE3 3'h4
`define MODE_CASE4 3'h5
`define CLOCK_HZ 50000000
`define PWM_TICK_HZ 2000000
`define PWM_DIV (`CLOCK_HZ / `PWM_TICK_HZ)
`define PWM_PERIOD 4096
`define PWM_DIV_LAST 5'h18
`define PWM_CNT_LAST 12'hfff
`endif

// file: src/sensor_config_alert_logic.v
// Setup word, anomaly flags, averaging filter and alert output of the sensor conditioner.
`timescale 1ns/1ns
`include "sensor_cfg_map.vh"

module sensor_config_alert_logic (
    input wire clock,
    input wire resetn,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire plc_mode,
    input wire thermistor_request,
    input wire [9:0] irq_enable_mask,
    input wire [15:0] primary_threshold,
    input wire [15:0] hysteresis_threshold,
    input wire pressure_sample_valid,
    input wire [15:0] pressure_sample,
    input wire temp_sample_valid,
    input wire [15:0] temp_sample,
    input wire cal_pressure_valid,
    input wire [15:0] cal_pressure,
    input wire cal_temp_valid,
    input wire [15:0] cal_temp,
    input wire drive_over_limit,
    input wire pos_input_drift,
    input wire neg_input_drift,
    input wire aux_over_limit,
    input wire [7:0] level_flag_events,
    output reg pressure_result_valid,
    output reg [15:0] pressure_result,
    output reg temp_result_valid,
    output reg [15:0] temp_result,
    output reg alert_n,
    output wire analog_enable,
    output wire measure_pressure,
    output wire measure_temp,
    output wire raw_pressure_out,
    output wire raw_temp_out,
    output wire [1:0] therm_current_code,
    output wire ext_resistor_select,
    output wire thermistor_enable,
    output wire converter_reference_select,
    output wire nvm_access_enable
);

    reg [15:0] sensor_setup_word;
    reg [11:0] anomaly_flags;
    // Block sums and sample counts of the averaging filter.
    reg [22:0] p_acc;
    reg [22:0] t_acc;
    reg [6:0] p_cnt;
    reg [6:0] t_cnt;
    // PWM timebase divider, period counter and the duty latched per period.
    reg [4:0] tick_div;
    reg [11:0] pwm_cnt;
    reg [11:0] pwm_duty;
    reg pwm_level;
    reg switch_state;
    reg [11:0] next_flags;
    reg [15:0] next_setup;
    reg next_alert_n;

    wire [2:0] alert_mode;
    wire [2:0] avg_code;
    wire [6:0] avg_last;
    wire [7:0] enabled_events;
    wire shutdown;
    wire p_take;
    wire t_take;
    wire tick;
    wire setup_sel;
    wire flags_sel;
    wire alert_any;

    // Number of right shifts that turn a block sum into its average.
    function [2:0] avg_shift;
        input [2:0] code;
        begin
            case (code)
                3'h1: avg_shift = 3'h2;
                3'h2: avg_shift = 3'h3;
                3'h3: avg_shift = 3'h4;
                3'h4: avg_shift = 3'h5;
                3'h5: avg_shift = 3'h6;
                3'h6: avg_shift = 3'h7;
                default: avg_shift = 3'h0;
            endcase
        end
    endfunction

    // Sign-extended sample added to a running block sum.
    function [22:0] acc_add;
        input [22:0] acc;
        input [15:0] sample;
        input first;
        begin
            if (first) begin
                acc_add = {{7{sample[15]}}, sample};
            end else begin
                acc_add = acc + {{7{sample[15]}}, sample};
            end
        end
    endfunction

    // Average of a completed block, arithmetic shift keeps the sign.
    function [15:0] acc_avg;
        input [22:0] sum;
        input [2:0] sh;
        reg [22:0] shifted;
        begin
            shifted = $signed(sum) >>> sh;
            acc_avg = shifted[15:0];
        end
    endfunction

    // Control fields decode straight from the setup word.
    assign alert_mode = sensor_setup_word[`ALERT_MODE_LSB+2:`ALERT_MODE_LSB];
    assign avg_code = sensor_setup_word[`AVG_LSB+2:`AVG_LSB];
    assign avg_last = (7'h1 << avg_shift(avg_code)) - 7'h1;
    assign shutdown = sensor_setup_word[`SHUTDOWN_BIT];
    assign analog_enable = ~shutdown;
    assign therm_current_code = sensor_setup_word[`THERM_CUR_LSB+1:`THERM_CUR_LSB];
    assign ext_resistor_select = sensor_setup_word[`EXT_RES_BIT];
    assign thermistor_enable = thermistor_request & ~ext_resistor_select;
    assign converter_reference_select = sensor_setup_word[`EXT_REF_BIT];
    assign nvm_access_enable = ~sensor_setup_word[`NVM_DISABLE_BIT];
    assign raw_pressure_out = sensor_setup_word[`P_BYPASS_BIT];
    assign raw_temp_out = sensor_setup_word[`T_BYPASS_BIT];
    assign measure_pressure = analog_enable & ~raw_temp_out;
    assign measure_temp = analog_enable & ~raw_pressure_out;
    assign p_take = pressure_sample_valid & measure_pressure;
    assign t_take = temp_sample_valid & measure_temp;
    // Only two addresses decode; all others read zero and ignore writes.
    assign setup_sel = reg_addr == `SETUP_OFFSET;
    assign flags_sel = reg_addr == `FLAGS_OFFSET;
    assign tick = tick_div == `PWM_DIV_LAST;
    // Faults always reach the interrupt-mode alert; the other flags only when enabled.
    assign enabled_events = anomaly_flags[7:0] & irq_enable_mask[7:0];
    assign alert_any = anomaly_flags[`DRIVE_FAULT_BIT] | anomaly_flags[`SENSE_FAULT_BIT] |
        (|enabled_events) |
        (anomaly_flags[`P_READY_BIT] & irq_enable_mask[8]) |
        (anomaly_flags[`T_READY_BIT] & irq_enable_mask[9]);

    // Register read data follows the address; unmapped addresses read zero.
    always @* begin
        if (setup_sel) begin
            reg_rdata = sensor_setup_word;
        end else if (flags_sel) begin
            reg_rdata = {4'h0, anomaly_flags};
        end else begin
            reg_rdata = 16'h0000;
        end
    end

    // Setup word write; reserved bit stays zero and shutdown is refused on power-line link.
    always @* begin
        next_setup = sensor_setup_word;
        if (reg_write && setup_sel) begin
            next_setup = reg_wdata & `SETUP_WRITE_MASK;
            if (plc_mode) begin
                next_setup[`SHUTDOWN_BIT] = 1'b0;
            end
        end
    end

    // Flags clear on written ones, but a new event in the same cycle wins.
    always @* begin
        next_flags = anomaly_flags;
        if (reg_write && flags_sel) begin
            next_flags = anomaly_flags & ~reg_wdata[11:0];
        end
        next_flags[7:0] = next_flags[7:0] | level_flag_events;
        if (drive_over_limit || pos_input_drift || neg_input_drift) begin
            next_flags[`DRIVE_FAULT_BIT] = 1'b1;
        end
        if (aux_over_limit) begin
            next_flags[`SENSE_FAULT_BIT] = 1'b1;
        end
        if (cal_pressure_valid) begin
            next_flags[`P_READY_BIT] = 1'b1;
        end
        if (cal_temp_valid) begin
            next_flags[`T_READY_BIT] = 1'b1;
        end
    end

    // Setup word and flags; a written value shows the cycle after the write.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sensor_setup_word <= `SETUP_RESET;
            anomaly_flags <= `FLAGS_RESET;
        end else begin
            sensor_setup_word <= next_setup;
            anomaly_flags <= next_flags;
        end
    end

    // Block averaging of converter samples; one result per full block.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            p_acc <= 23'h000000;
            t_acc <= 23'h000000;
            p_cnt <= 7'h00;
            t_cnt <= 7'h00;
            pressure_result_valid <= 1'b0;
            pressure_result <= 16'h0000;
            temp_result_valid <= 1'b0;
            temp_result <= 16'h0000;
        end else begin
            pressure_result_valid <= 1'b0;
            temp_result_valid <= 1'b0;
            if (p_take) begin
                p_acc <= acc_add(p_acc, pressure_sample, p_cnt == 7'h00);
                if (p_cnt >= avg_last) begin
                    p_cnt <= 7'h00;
                    pressure_result <= acc_avg(acc_add(p_acc, pressure_sample,
                        p_cnt == 7'h00), avg_shift(avg_code));
                    pressure_result_valid <= 1'b1;
                end else begin
                    p_cnt <= p_cnt + 7'h1;
                end
            end
            if (t_take) begin
                t_acc <= acc_add(t_acc, temp_sample, t_cnt == 7'h00);
                if (t_cnt >= avg_last) begin
                    t_cnt <= 7'h00;
                    temp_result <= acc_avg(acc_add(t_acc, temp_sample,
                        t_cnt == 7'h00), avg_shift(avg_code));
                    temp_result_valid <= 1'b1;
                end else begin
                    t_cnt <= t_cnt + 7'h1;
                end
            end
        end
    end

    // Temperature PWM on a 2 MHz timebase; duty is reloaded at each period start.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_div <= 5'h00;
            pwm_cnt <= 12'h000;
            pwm_duty <= 12'h000;
            pwm_level <= 1'b0;
        end else begin
            if (tick) begin
                tick_div <= 5'h00;
                pwm_cnt <= pwm_cnt + 12'h1;
                if (pwm_cnt == `PWM_CNT_LAST) begin
                    pwm_duty <= cal_temp[15:4];
                end
            end else begin
                tick_div <= tick_div + 5'h1;
            end
            pwm_level <= pwm_cnt < pwm_duty;
        end
    end

    // Hysteretic pressure switch, evaluated on each new calibrated pressure.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            switch_state <= 1'b0;
        end else if (cal_pressure_valid) begin
            if (alert_mode == `MODE_CASE1 || alert_mode == `MODE_CASE2) begin
                if ($signed(cal_pressure) > $signed(primary_threshold)) begin
                    switch_state <= 1'b1;
                end else if ($signed(cal_pressure) < $signed(hysteresis_threshold)) begin
                    switch_state <= 1'b0;
                end
            end else begin
                if ($signed(cal_pressure) < $signed(primary_threshold)) begin
                    switch_state <= 1'b1;
                end else if ($signed(cal_pressure) > $signed(hysteresis_threshold)) begin
                    switch_state <= 1'b0;
                end
            end
        end
    end

    // Alert pin selection; interrupts pull it low, PWM mode gives the waveform level, cases 1 and 3 give the switch state, cases 2 and 4 its inverse.
    always @* begin
        case (alert_mode)
            `MODE_IRQ: next_alert_n = ~alert_any;
            `MODE_PWM: next_alert_n = pwm_level;
            `MODE_CASE1: next_alert_n = switch_state;
            `MODE_CASE2: next_alert_n = ~switch_state;
            `MODE_CASE3: next_alert_n = switch_state;
            `MODE_CASE4: next_alert_n = ~switch_state;
            default: next_alert_n = 1'b1;
        endcase
    end

    // Registered pin, so it cannot glitch while the mode field changes.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= next_alert_n;
        end
    end

endmodule

// file: testbench/sensor_alert_properties.sv
// Concurrent checks on the setup word, flag read-back and fault alerts.
`timescale 1ns/1ns
`include "sensor_cfg_map.vh"
module sensor_alert_checker (
    input wire clock,
    input wire resetn,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire plc_mode,
    input wire drive_over_limit,
    input wire aux_over_limit,
    input wire alert_n,
    input wire analog_enable,
    input wire [1:0] therm_current_code,
    input wire ext_resistor_select,
    input wire thermistor_enable,
    input wire converter_reference_select,
    input wire nvm_access_enable
);
    reg [2:0] mode;
    wire setup_hit = reg_write && reg_addr == `SETUP_OFFSET;
    wire setup_wr = setup_hit && !plc_mode;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Shadow of the alert mode field, taken from the write traffic.
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            mode <= 3'h0;
        else if (setup_hit)
            mode <= reg_wdata[3:1];
    end
    setup_read_a: assert property (setup_wr |=> reg_addr != `SETUP_OFFSET ||
        reg_rdata == ($past(reg_wdata) & `SETUP_WRITE_MASK)) else $error("setup readback bad");
    plc_guard_a: assert property (setup_hit && plc_mode |=> analog_enable)
        else $error("shutdown entered in plc mode");
    shutdown_bit_a: assert property (setup_wr |=> analog_enable == !$past(reg_wdata[7]))
        else $error("shutdown bit not followed");
    decode_fields_a: assert property (setup_wr |=> therm_current_code == $past(reg_wdata[5:4])
        && ext_resistor_select == $past(reg_wdata[8])
        && converter_reference_select == $past(reg_wdata[9])) else $error("setup fields bad");
    nvm_bit_a: assert property (setup_wr |=> nvm_access_enable == !$past(reg_wdata[15]))
        else $error("nvm enable bad");
    therm_excl_a: assert property (ext_resistor_select |-> !thermistor_enable)
        else $error("thermistor with external resistor");
    flags_width_a: assert property (reg_addr == `FLAGS_OFFSET |-> reg_rdata[15:12] == 4'h0)
        else $error("flag upper bits set");
    drive_alert_a: assert property (drive_over_limit && mode == `MODE_IRQ && !reg_write
        |-> ##2 !alert_n) else $error("drive fault gave no alert");
    sense_alert_a: assert property (aux_over_limit && mode == `MODE_IRQ && !reg_write
        |-> ##2 !alert_n) else $error("sense fault gave no alert");
endmodule
bind sensor_config_alert_logic sensor_alert_checker i_chk (.clock, .resetn, .reg_write,
    .reg_addr, .reg_wdata, .reg_rdata, .plc_mode, .drive_over_limit, .aux_over_limit,
    .alert_n, .analog_enable, .therm_current_code, .ext_resistor_select, .thermistor_enable,
    .converter_reference_select, .nvm_access_enable);

// file: testbench/host_model.sv
// Host processor model that reads and writes the setup and flag registers.
`timescale 1ns/1ns
module host_model (
    input wire clock,
    output reg reg_write = 1'b0,
    output reg [7:0] reg_addr = 8'h00,
    output reg [15:0] reg_wdata = 16'h0000,
    input wire [15:0] reg_rdata
);
    // One strobe per word; the data lines are scrambled once it drops.
    task write_word(input [7:0] a, input [15:0] d);
        begin
            @(posedge clock);
            reg_write <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_write <= 1'b0;
            reg_wdata <= ~d;
        end
    endtask
    task read_word(input [7:0] a, output [15:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            @(posedge clock);
            d = reg_rdata;
        end
    endtask
    // Flags are cleared by writing back the read word, upper bits filled with junk.
    task clear_flags(output [15:0] d);
        begin
            read_word(8'h01, d);
            write_word(8'h01, d | 16'hf000);
        end
    endtask
endmodule

// file: testbench/sensor_config_alert_logic_tb.sv
// Self-checking bench for the sensor setup, flag and alert logic.
`timescale 1ns/1ns
module sensor_config_alert_logic_tb;
    reg clock = 1'b0, resetn = 1'b0, plc_mode = 1'b0, thermistor_request = 1'b1;
    reg pressure_sample_valid = 1'b0, temp_sample_valid = 1'b0, cal_pressure_valid = 1'b0;
    reg cal_temp_valid = 1'b0, drive_over_limit = 1'b0, pos_input_drift = 1'b0;
    reg neg_input_drift = 1'b0, aux_over_limit = 1'b0;
    reg [7:0] level_flag_events = 8'h00;
    reg [9:0] irq_enable_mask = 10'h000;
    reg [15:0] primary_threshold = 16'h0000, hysteresis_threshold = 16'h0000;
    reg [15:0] pressure_sample = 16'h0000, temp_sample = 16'h0000;
    reg [15:0] cal_pressure = 16'h0000, cal_temp = 16'h0000, rd;
    wire reg_write, pressure_result_valid, alert_n, analog_enable, measure_temp;
    wire temp_result_valid, measure_pressure, raw_temp_out;
    wire raw_pressure_out, ext_resistor_select, thermistor_enable;
    wire converter_reference_select, nvm_access_enable;
    wire [7:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata, pressure_result, temp_result;
    wire [1:0] therm_current_code;
    integer fail_count = 0, n_checks = 0;
    always #10 clock = ~clock;
    host_model host (.clock, .reg_write, .reg_addr, .reg_wdata, .reg_rdata);
    sensor_config_alert_logic i_dut (.clock, .resetn, .reg_write, .reg_addr, .reg_wdata,
        .reg_rdata, .plc_mode, .thermistor_request, .irq_enable_mask, .primary_threshold,
        .hysteresis_threshold, .pressure_sample_valid, .pressure_sample, .temp_sample_valid,
        .temp_sample, .cal_pressure_valid, .cal_pressure, .cal_temp_valid, .cal_temp,
        .drive_over_limit, .pos_input_drift, .neg_input_drift, .aux_over_limit,
        .level_flag_events, .pressure_result_valid, .pressure_result, .temp_result_valid,
        .temp_result, .alert_n, .analog_enable, .measure_pressure, .measure_temp,
        .raw_pressure_out, .raw_temp_out, .therm_current_code, .ext_resistor_select,
        .thermistor_enable, .converter_reference_select, .nvm_access_enable);
    task check(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            if (fail_count == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task t_setup;
        integer i;
        begin
            check({alert_n, analog_enable, nvm_access_enable}, 16'h0007);
            host.read_word(8'h00, rd);
            check(rd, 16'h0000);
            host.write_word(8'h00, 16'hffff);
            host.read_word(8'h00, rd);
            check(rd, 16'hffbf);
            check({analog_enable, nvm_access_enable, measure_temp, measure_pressure, raw_temp_out},
                16'h0001);
            check({ext_resistor_select, thermistor_enable, converter_reference_select},
                16'h0005);
            for (i = 0; i < 4; i = i + 1) begin
                host.write_word(8'h00, {10'h080, i[1:0], 4'h0});
                @(posedge clock);
                check(therm_current_code, i[1:0]);
                check({measure_temp, raw_pressure_out, thermistor_enable}, 16'h0003);
            end
            plc_mode <= 1'b1;
            host.write_word(8'h00, 16'h0080);
            @(posedge clock);
            check(analog_enable, 1'b1);
            plc_mode <= 1'b0;
        end
    endtask
    task t_irq;
        integer i;
        begin
            host.clear_flags(rd);
            level_flag_events <= 8'h01;
            @(posedge clock);
            level_flag_events <= 8'h00;
            cal_pressure_valid <= 1'b1;
            @(posedge clock);
            cal_pressure_valid <= 1'b0;
            cal_temp_valid <= 1'b1;
            @(posedge clock);
            cal_temp_valid <= 1'b0;
            repeat (3) @(posedge clock);
            check(alert_n, 1'b1);
            host.read_word(8'h01, rd);
            check(rd, 16'h0301);
            irq_enable_mask <= 10'h001;
            repeat (3) @(posedge clock);
            check(alert_n, 1'b0);
            host.clear_flags(rd);
            repeat (3) @(posedge clock);
            check(alert_n, 1'b1);
            for (i = 0; i < 4; i = i + 1) begin
                {drive_over_limit, pos_input_drift, neg_input_drift, aux_over_limit} <= 4'h8 >> i;
                @(posedge clock);
                {drive_over_limit, pos_input_drift, neg_input_drift, aux_over_limit} <= 4'h0;
                repeat (3) @(posedge clock);
                check(alert_n, 1'b0);
                host.clear_flags(rd);
                check(rd, i < 3 ? 16'h0800 : 16'h0400);
            end
            host.write_word(8'h00, 16'h0080);
            @(posedge clock);
            check(analog_enable, 1'b0);
        end
    endtask
    task t_avg;
        integer code, i, n;
        begin
            for (code = 0; code < 7; code = code + 1) begin
                n = (code == 0) ? 1 : (2 << code);
                host.write_word(8'h00, {3'h0, code[2:0], 10'h000});
                pressure_sample <= {12'hfff, code[3:0]};
                temp_sample <= {12'h010, code[3:0]};
                pressure_sample_valid <= 1'b1;
                temp_sample_valid <= 1'b1;
                for (i = 1; i <= n + 1; i = i + 1) begin
                    @(posedge clock);
                    if (i == n) begin
                        pressure_sample_valid <= 1'b0;
                        temp_sample_valid <= 1'b0;
                    end
                    check({pressure_result_valid, temp_result_valid},
                        (i == n + 1) ? 16'h0003 : 16'h0000);
                end
                check(pressure_result, {12'hfff, code[3:0]});
                check(temp_result, {12'h010, code[3:0]});
            end
        end
    endtask
    task t_cases;
        integer m, i, d;
        begin
            for (m = 2; m < 6; m = m + 1) begin
                primary_threshold <= (m < 4) ? 16'd100 : 16'd60;
                hysteresis_threshold <= (m < 4) ? 16'd60 : 16'd100;
                host.write_word(8'h00, {12'h000, m[2:0], 1'b0});
                for (i = 0; i < 5; i = i + 1) begin
                    d = (i > 2) ? i - 2 : 2 - i;
                    cal_pressure <= (m < 4) ? 16'd40 + 16'd40 * d[1:0] : 16'd120 - 16'd40 * d[1:0];
                    cal_pressure_valid <= 1'b1;
                    @(posedge clock);
                    cal_pressure_valid <= 1'b0;
                    repeat (3) @(posedge clock);
                    check(alert_n, (i < 2 || i == 4) ^ m[0]);
                end
            end
            host.write_word(8'h00, 16'h000c);
            repeat (3) @(posedge clock);
            check(alert_n, 1'b1);
            host.write_word(8'h00, 16'h0002);
            repeat (3) @(posedge clock);
            check(alert_n, 1'b0);
        end
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        t_setup;
        t_irq;
        t_avg;
        t_cases;
        end_sim;
    end
    initial begin
        repeat (100000) @(posedge clock);
        fail_count = fail_count + 1;
        end_sim;
    end
endmodule
